// File: tb/testbench.sv
// self-checking bench for the converter sequencer register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_fail++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic crystal_ref_clock = 1'b0;
  logic comparator_high = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic core_power_down, sample_hold, conv_irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [4:0] channel_select;
  logic [7:0] dac_code;
  logic [7:0] level = 8'h00;
  logic [2:0] xcnt = 3'h0;
  int n_fail = 0;
  int tests_run = 0;
  int n;

  always #20 aclk = ~aclk;

  // comparator answers a cycle late, so conversions use divide 4 or slower
  always @(posedge aclk)
  begin
    comparator_high <= (level >= dac_code);
    xcnt <= (xcnt == 3'h2) ? 3'h0 : xcnt + 3'h1;
    if (xcnt == 3'h2)
      crystal_ref_clock <= ~crystal_ref_clock;
  end

  adc_sequencer_control uut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .crystal_ref_clock(crystal_ref_clock),
    .comparator_high(comparator_high), .channel_select(channel_select),
    .core_power_down(core_power_down), .sample_hold(sample_hold),
    .dac_code(dac_code), .conv_irq(conv_irq)
  );

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    // one idle edge keeps the next request off this edge
    @(posedge aclk);
  endtask : wr

  task automatic rd_reg(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd_reg

  task automatic wait_flag();
    int k;
    for (k = 0; k < 80; k++)
    begin
      rd_reg(adc_pkg::ADDR_STATUS);
      if (rd[7] === 1'b1)
        break;
    end
    `CHK("flagwait", 1'b1, rd[7])
  endtask : wait_flag

  // first conversion after power-up only settles the analog side
  task automatic warm_up();
    wr(adc_pkg::ADDR_STATUS, 8'h00);
    wait_flag();
  endtask : warm_up

  task automatic wait_irq();
    int k;
    for (k = 0; k < 300 && conv_irq !== 1'b1; k++)
      @(posedge aclk);
  endtask : wait_irq

  // part of the sample phase passes inside the write, hence loose lower bound
  task automatic sample_len(output int len);
    int k;
    len = 0;
    for (k = 0; k < 400 && (len == 0 || sample_hold); k++)
    begin
      @(posedge aclk);
      if (sample_hold)
        len++;
    end
  endtask : sample_len

  task automatic t_reset();
    `CHK("pwr", 1'b1, core_power_down)
    `CHK("irq", 1'b0, conv_irq)
    rd_reg(adc_pkg::ADDR_STATUS);
    `CHK("status", 32'h1f, rd)
    rd_reg(adc_pkg::ADDR_RESULT);
    `CHK("result", 32'h0, rd)
    rd_reg(adc_pkg::ADDR_CLOCK);
    `CHK("clock", 32'h0, rd)
  endtask : t_reset

  task automatic t_channels();
    int c;
    for (c = 0; c < 31; c++)
    begin
      wr(adc_pkg::ADDR_STATUS, 8'(c));
      `CHK("chan", c[4:0], channel_select)
      `CHK("pwr", 1'b0, core_power_down)
    end
    wr(adc_pkg::ADDR_STATUS, 8'h1f);
    `CHK("pwr", 1'b1, core_power_down)
    n = 0;
    repeat (100)
    begin
      @(posedge aclk);
      if (sample_hold)
        n++;
    end
    `CHK("idle", 0, n)
  endtask : t_channels

  task automatic t_prescale();
    int p;
    int dv;
    logic [2:0] ps;
    for (p = 0; p < 6; p++)
    begin
      ps = (p == 5) ? 3'h7 : 3'(p);
      dv = (p >= 4) ? 16 : (1 << p);
      wr(adc_pkg::ADDR_CLOCK, {ps, 5'h10});
      rd_reg(adc_pkg::ADDR_CLOCK);
      `CHK("clkreg", {24'h0, ps, 5'h10}, rd)
      wr(adc_pkg::ADDR_STATUS, 8'h00);
      sample_len(n);
      `CHK("div", 1'b1, n >= 7 * dv - 3 && n <= 8 * dv)
      // stop before the divider is touched again
      wr(adc_pkg::ADDR_STATUS, 8'h1f);
    end
    // crystal near 4.2 MHz over 4 gives a converter clock near 1 MHz
    wr(adc_pkg::ADDR_CLOCK, 8'h40);
    wr(adc_pkg::ADDR_STATUS, 8'h00);
    sample_len(n);
    `CHK("xtal", 1'b1, n >= 165 && n <= 192)
    wr(adc_pkg::ADDR_STATUS, 8'h1f);
  endtask : t_prescale

  task automatic t_single();
    wr(adc_pkg::ADDR_CLOCK, 8'h50);
    warm_up();
    level <= 8'hc3;
    wr(adc_pkg::ADDR_STATUS, 8'h04);
    wait_flag();
    `CHK("flag", 32'h84, rd)
    rd_reg(adc_pkg::ADDR_RESULT);
    `CHK("result", 32'hc3, rd)
    rd_reg(adc_pkg::ADDR_STATUS);
    `CHK("flagclr", 32'h04, rd)
    n = 0;
    repeat (100)
    begin
      @(posedge aclk);
      if (sample_hold)
        n++;
    end
    `CHK("once", 0, n)
    wr(adc_pkg::ADDR_STATUS, 8'h04);
    wait_flag();
    wr(adc_pkg::ADDR_STATUS, 8'h1f);
    rd_reg(adc_pkg::ADDR_STATUS);
    `CHK("wrclr", 32'h1f, rd)
  endtask : t_single

  task automatic t_irq();
    warm_up();
    level <= 8'h5a;
    wr(adc_pkg::ADDR_STATUS, 8'h43);
    wait_irq();
    `CHK("irq", 1'b1, conv_irq)
    rd_reg(adc_pkg::ADDR_STATUS);
    `CHK("bit7", 32'h43, rd)
    rd_reg(adc_pkg::ADDR_RESULT);
    `CHK("result", 32'h5a, rd)
    `CHK("irqrd", 1'b0, conv_irq)
    wr(adc_pkg::ADDR_STATUS, 8'h43);
    wait_irq();
    `CHK("irq", 1'b1, conv_irq)
    wr(adc_pkg::ADDR_STATUS, 8'h1f);
    `CHK("irqwr", 1'b0, conv_irq)
  endtask : t_irq

  task automatic t_cont();
    warm_up();
    level <= 8'h3c;
    wr(adc_pkg::ADDR_STATUS, 8'h22);
    wait_flag();
    rd_reg(adc_pkg::ADDR_RESULT);
    `CHK("cont", 32'h3c, rd)
    level <= 8'ha5;
    wait_flag();
    rd_reg(adc_pkg::ADDR_RESULT);
    wait_flag();
    rd_reg(adc_pkg::ADDR_RESULT);
    `CHK("cont", 32'ha5, rd)
    wr(adc_pkg::ADDR_STATUS, 8'h1f);
  endtask : t_cont

  task automatic t_abort();
    warm_up();
    level <= 8'h77;
    wr(adc_pkg::ADDR_STATUS, 8'h01);
    // leave the sample phase so the write lands mid-trial
    sample_len(n);
    wr(adc_pkg::ADDR_STATUS, 8'h02);
    `CHK("restart", 1'b1, sample_hold)
    wait_flag();
    `CHK("chan", 5'h02, channel_select)
    rd_reg(adc_pkg::ADDR_RESULT);
    `CHK("result", 32'h77, rd)
    wr(adc_pkg::ADDR_RESULT, 8'h12);
    `CHK("roresp", adc_pkg::RESP_OKAY, rsp)
    rd_reg(adc_pkg::ADDR_RESULT);
    `CHK("ro", 32'h77, rd)
    rd_reg(4'hc);
    `CHK("slverr", adc_pkg::RESP_SLVERR, rsp)
    `CHK("unmap", 32'h0, rd)
    wr(4'hc, 8'h55);
    `CHK("slverr", adc_pkg::RESP_SLVERR, rsp)
  endtask : t_abort

  task automatic report_and_stop();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // whole run is some 2000 to 3000 cycles; the limit of 80000 leaves ample slack
  initial
  begin
    #(40 * 80000);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_channels();
    t_prescale();
    t_single();
    t_irq();
    t_cont();
    t_abort();
    report_and_stop();
  end
endmodule : testbench

// File: verilog/adc_clock_prescaler.sv
// divider that turns source ticks into converter clock enables
`timescale 1ns/1ps
module adc_clock_prescaler
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic src_tick,
  input wire logic [2:0] prescale,
  output logic conv_tick
);

  logic [3:0] count_q;
  logic [3:0] count_d;
  logic [2:0] shift_sel;
  logic [3:0] last_count;
  logic wrap;

  // 1xx all mean divide by 16
  assign shift_sel = (prescale >= adc_pkg::PRESC_CAP) ?
                     adc_pkg::PRESC_CAP : prescale;
  assign last_count = 4'((5'h01 << shift_sel) - 5'h01);
  assign wrap = src_tick && (count_q >= last_count);
  assign count_d = wrap ? 4'h0 : (src_tick ? count_q + 4'h1 : count_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= 4'h0;
      conv_tick <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      conv_tick <= wrap;
    end
  end

endmodule : adc_clock_prescaler

// File: verilog/adc_pkg.sv
// constants shared by the converter sequencer and its clock divider
package adc_pkg;

  // register map (byte addresses on the lite bus)
  localparam int AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] ADDR_STATUS = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] ADDR_RESULT = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] ADDR_CLOCK = 4'h8;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // status_control_reg field positions
  localparam int FLAG_BIT = 7;
  localparam int IRQEN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int CH_MSB = 4;

  // converter_clock_select field positions
  localparam int PRESC_MSB = 7;
  localparam int PRESC_LSB = 5;
  localparam int SRC_BIT = 4;

  // reset values and special channel codes
  localparam logic [4:0] CH_RESET = 5'h1f;
  localparam logic [4:0] CH_POWER_OFF = 5'h1f;
  localparam logic [4:0] CH_HIGH_REF = 5'h1d;
  localparam logic [4:0] CH_LOW_REF = 5'h1e;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam logic SRC_RESET = 1'b0;

  // prescaler: codes of 4 and above all divide by 16
  localparam logic [2:0] PRESC_CAP = 3'h4;

  // conversion timing in converter clock ticks, and the first trial code
  localparam logic [3:0] SAMPLE_TICKS = 4'h8;
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [7:0] SAR_FIRST = 8'h80;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_TRIAL = 3'b100
  } conv_state_t;

endpackage : adc_pkg

// File: verilog/adc_sequencer_control.sv
// successive approximation sequencer with its lite register slave
`timescale 1ns/1ps
// Operation
// - flag reads 1 after completion, irq off
// - flag bit reads 0 when irq enabled
// - irq enabled: request at each conversion end
// - result read or status write drops request
// - reset clears flags, channel bits all one
// - continuous mode converts back to back
// - single mode: one conversion per start
// - channel codes 0 to 14 pick inputs
// - unused and reserved codes give undefined result
// - codes 1d/1e route high/low reference
// - all ones powers converter down
// - one 8-bit result, overwritten each completion
// - prescale field divides by 1,2,4,8,16
// - source bit: 1 bus, 0 crystal; reset crystal
// - flag set at end, cleared by write/read
// - status write starts; 16 to 17 ticks
module adc_sequencer_control
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [adc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic crystal_ref_clock,
  input wire logic comparator_high,
  output logic [4:0] channel_select,
  output logic core_power_down,
  output logic sample_hold,
  output logic [7:0] dac_code,
  output logic conv_irq
);

  adc_pkg::conv_state_t state_q;
  logic [adc_pkg::AXI_ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic aw_have_q;
  logic w_have_q;
  logic irq_en_q;
  logic cont_q;
  logic complete_q;
  logic [2:0] prescale_q;
  logic clk_src_q;
  logic [7:0] result_q;
  logic [7:0] sar_q;
  logic [7:0] mask_q;
  logic [3:0] sample_cnt_q;
  logic xclk_s1_q;
  logic xclk_s2_q;
  logic xclk_s3_q;

  // bus decode
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_exec;
  logic wr_status;
  logic wr_clock;
  logic wr_mapped;
  logic rd_result;
  logic rd_mapped;
  logic [7:0] status_view;
  logic [7:0] clock_view;
  logic [7:0] rd_byte;
  logic [4:0] new_channel;

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_exec = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_mapped = (awaddr_q == adc_pkg::ADDR_STATUS) ||
                     (awaddr_q == adc_pkg::ADDR_RESULT) ||
                     (awaddr_q == adc_pkg::ADDR_CLOCK);
  // a write with the low byte lane off stores nothing and starts nothing
  assign wr_status = wr_exec && wlane_q &&
                     (awaddr_q == adc_pkg::ADDR_STATUS);
  assign wr_clock = wr_exec && wlane_q && (awaddr_q == adc_pkg::ADDR_CLOCK);
  assign rd_result = ar_hs && (s_axi_araddr == adc_pkg::ADDR_RESULT);
  assign rd_mapped = (s_axi_araddr == adc_pkg::ADDR_STATUS) ||
                     (s_axi_araddr == adc_pkg::ADDR_RESULT) ||
                     (s_axi_araddr == adc_pkg::ADDR_CLOCK);
  assign new_channel = wbyte_q[adc_pkg::CH_MSB:0];

  // the flag position reads 0 once interrupts are on; a written bit 7 is not stored
  assign status_view = {(complete_q && !irq_en_q), irq_en_q, cont_q,
                        channel_select};
  assign clock_view = {prescale_q, clk_src_q, 4'h0};
  assign rd_byte =
    (s_axi_araddr == adc_pkg::ADDR_STATUS) ? status_view :
    (s_axi_araddr == adc_pkg::ADDR_RESULT) ? result_q :
    (s_axi_araddr == adc_pkg::ADDR_CLOCK) ? clock_view : 8'h00;

  // ready is raised for one cycle after valid, so each channel takes
  // at most one item per transaction and the slave needs no skid
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= adc_pkg::ADDR_STATUS;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_have_q &&
                       !s_axi_bvalid;
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_have_q &&
                      !s_axi_bvalid;
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (aw_hs)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_exec)
        aw_have_q <= 1'b0;
      if (w_hs)
      begin
        w_have_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      else if (wr_exec)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= adc_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= adc_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (wr_exec)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? adc_pkg::RESP_OKAY : adc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (ar_hs)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_mapped ? adc_pkg::RESP_OKAY : adc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // crystal clock is foreign: two flops, then a third for the edge
  logic xclk_rise;
  logic src_tick;
  logic conv_tick;

  assign xclk_rise = xclk_s2_q && !xclk_s3_q;
  assign src_tick = clk_src_q ? 1'b1 : xclk_rise;

  adc_clock_prescaler u_prescaler
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_tick(src_tick),
    .prescale(prescale_q),
    .conv_tick(conv_tick)
  );

  // successive approximation step
  logic [7:0] code_kept;
  logic done;
  logic start;
  logic sample_end;

  assign code_kept = comparator_high ? sar_q : (sar_q & ~mask_q);
  assign done = conv_tick && (state_q == adc_pkg::ST_TRIAL) && mask_q[0];
  assign sample_end = conv_tick && (state_q == adc_pkg::ST_SAMPLE) &&
                      (sample_cnt_q == adc_pkg::SAMPLE_TICKS - 4'h1);
  // power-off code is stored but never converts
  assign start = wr_status &&
                 (new_channel != adc_pkg::CH_POWER_OFF);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xclk_s1_q <= 1'b0;
      xclk_s2_q <= 1'b0;
      xclk_s3_q <= 1'b0;
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
      channel_select <= adc_pkg::CH_RESET;
      core_power_down <= 1'b1;
      prescale_q <= adc_pkg::PRESC_RESET;
      clk_src_q <= adc_pkg::SRC_RESET;
    end
    else
    begin
      xclk_s1_q <= crystal_ref_clock;
      xclk_s2_q <= xclk_s1_q;
      xclk_s3_q <= xclk_s2_q;
      if (wr_status)
      begin
        irq_en_q <= wbyte_q[adc_pkg::IRQEN_BIT];
        cont_q <= wbyte_q[adc_pkg::CONT_BIT];
        // the analog mux decodes these codes, reference codes included
        channel_select <= new_channel;
        core_power_down <= (new_channel == adc_pkg::CH_POWER_OFF);
      end
      if (wr_clock)
      begin
        // taken at once: a change mid-conversion spoils that result
        prescale_q <= wbyte_q[adc_pkg::PRESC_MSB:adc_pkg::PRESC_LSB];
        clk_src_q <= wbyte_q[adc_pkg::SRC_BIT];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= adc_pkg::ST_IDLE;
      sar_q <= 8'h00;
      mask_q <= 8'h00;
      sample_cnt_q <= 4'h0;
      result_q <= 8'h00;
    end
    else if (wr_status)
    begin
      // restart drops any conversion under way
      state_q <= start ? adc_pkg::ST_SAMPLE : adc_pkg::ST_IDLE;
      sample_cnt_q <= 4'h0;
      sar_q <= 8'h00;
      mask_q <= 8'h00;
      // a conversion ending in the write's cycle still lands
      if (done)
        result_q <= code_kept;
    end
    else
    begin
      case (state_q)
        adc_pkg::ST_IDLE:
          state_q <= adc_pkg::ST_IDLE;
        adc_pkg::ST_SAMPLE:
          if (sample_end)
          begin
            state_q <= adc_pkg::ST_TRIAL;
            sar_q <= adc_pkg::SAR_FIRST;
            mask_q <= adc_pkg::SAR_FIRST;
          end
          else if (conv_tick)
            sample_cnt_q <= sample_cnt_q + 4'h1;
        adc_pkg::ST_TRIAL:
          if (done)
          begin
            result_q <= code_kept;
            sample_cnt_q <= 4'h0;
            state_q <= cont_q ? adc_pkg::ST_SAMPLE
                              : adc_pkg::ST_IDLE;
          end
          else if (conv_tick)
          begin
            sar_q <= code_kept | (mask_q >> 1);
            mask_q <= mask_q >> 1;
          end
        default:
          state_q <= adc_pkg::ST_IDLE;
      endcase
    end
  end

  assign sample_hold = state_q[1];
  assign dac_code = sar_q;

  // event wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      complete_q <= 1'b0;
      conv_irq <= 1'b0;
    end
    else
    begin
      if (done)
        complete_q <= 1'b1;
      else if (wr_status || rd_result)
        complete_q <= 1'b0;
      if (done && irq_en_q)
        conv_irq <= 1'b1;
      else if (wr_status || rd_result)
        conv_irq <= 1'b0;
    end
  end

  // helper: ticks seen in the current conversion
  logic [4:0] tick_cnt_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || wr_status || state_q == adc_pkg::ST_IDLE || done)
      tick_cnt_q <= 5'h00;
    else if (conv_tick)
      tick_cnt_q <= tick_cnt_q + 5'h01;
  end

  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn)
    done && !irq_en_q && !wr_status |=> complete_q &&
      status_view[adc_pkg::FLAG_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not shown after conversion end");

  property p_flag_hidden;
    @(posedge aclk) disable iff (!aresetn)
    irq_en_q |-> !status_view[adc_pkg::FLAG_BIT];
  endproperty
  a_flag_hidden: assert property (p_flag_hidden)
    else $error("flag bit visible with interrupts enabled");

  property p_irq_set;
    @(posedge aclk) disable iff (!aresetn)
    done && irq_en_q |=> conv_irq;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("no interrupt at conversion end");

  property p_irq_clear;
    @(posedge aclk) disable iff (!aresetn)
    (rd_result || wr_status) && !done |=> !conv_irq && !complete_q;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("request not removed by read or write");

  property p_reset_vals;
    @(posedge aclk)
    $rose(aresetn) |-> channel_select == adc_pkg::CH_RESET && !irq_en_q &&
      !cont_q && !complete_q && !clk_src_q;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong values after reset");

  property p_continuous;
    @(posedge aclk) disable iff (!aresetn)
    done && cont_q && !wr_status |=> state_q == adc_pkg::ST_SAMPLE;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous mode did not restart");

  property p_single;
    @(posedge aclk) disable iff (!aresetn)
    done && !cont_q && !wr_status |=> state_q == adc_pkg::ST_IDLE ##1
      (state_q == adc_pkg::ST_IDLE || $past(start));
  endproperty
  a_single: assert property (p_single)
    else $error("single mode did not stop");

  property p_power_off;
    @(posedge aclk) disable iff (!aresetn)
    channel_select == adc_pkg::CH_POWER_OFF |->
      state_q == adc_pkg::ST_IDLE && core_power_down;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("conversion while powered off");

  property p_result;
    @(posedge aclk) disable iff (!aresetn)
    done |=> result_q == $past(code_kept);
  endproperty
  a_result: assert property (p_result)
    else $error("result not loaded at completion");

  property p_length;
    @(posedge aclk) disable iff (!aresetn)
    done |-> tick_cnt_q == adc_pkg::CONV_TICKS - 5'h01;
  endproperty
  a_length: assert property (p_length)
    else $error("conversion length not sixteen ticks");

  c_continuous: cover property (@(posedge aclk) disable iff (!aresetn)
    done && cont_q ##[1:1000] done);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
    done && irq_en_q);
  c_abort: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_status && state_q == adc_pkg::ST_TRIAL);

endmodule : adc_sequencer_control
